//--- hw/adc_cfg_pkg.sv
// Constants, register map and field layout of the converter configuration bank
//
// Function
// - Reset bit clears all registers, self-clears
// - Readback line floats unless readback enabled
// - All registers read zero after reset
// - One write updates every field together
// - Swing code in bits 7..2 of 01h
// - Performance mode 00 default, 11 best
// - Gain nibble per channel, half-dB steps
// - Channel A pattern selects output source
// - Channel B pattern acts on B only
// - Toggle pattern alternates 1010 and 0101
// - Custom word from 3Fh and 40h
// - Format 11 offset binary, else twos
// - Sixteen-bit word, address then data
// - Readback enabled blocks writes, shifts data out
// - Excess bits dropped, many words per frame
package adc_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int WORD_BITS = 16;
  localparam int SAMPLE_W = 14;
  localparam int NUM_REGS = 23;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [4:0] CNT_RESET = 5'h00;
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_SWING = 8'h01;
  localparam logic [ADDR_W-1:0] A_PERF = 8'h03;
  localparam logic [ADDR_W-1:0] A_CHA = 8'h25;
  localparam logic [ADDR_W-1:0] A_FMT = 8'h29;
  localparam logic [ADDR_W-1:0] A_CHB = 8'h2B;
  localparam logic [ADDR_W-1:0] A_OFSEN = 8'h3D;
  localparam logic [ADDR_W-1:0] A_WORD_HI = 8'h3F;
  localparam logic [ADDR_W-1:0] A_WORD_LO = 8'h40;
  localparam logic [ADDR_W-1:0] A_IFC = 8'h41;
  localparam logic [ADDR_W-1:0] A_CLKPOS = 8'h42;
  localparam logic [ADDR_W-1:0] A_PDN = 8'h45;
  localparam logic [ADDR_W-1:0] A_HFB = 8'h4A;
  localparam logic [ADDR_W-1:0] A_HFA = 8'h58;
  localparam logic [ADDR_W-1:0] A_PEDA = 8'hBF;
  localparam logic [ADDR_W-1:0] A_PEDB = 8'hC1;
  localparam logic [ADDR_W-1:0] A_OFSLOOP = 8'hCF;
  localparam logic [ADDR_W-1:0] A_PERF45 = 8'hD5;
  localparam logic [ADDR_W-1:0] A_PERF67 = 8'hD7;
  localparam logic [ADDR_W-1:0] A_PERF8 = 8'hDB;
  localparam logic [ADDR_W-1:0] A_SLOWEN = 8'hEF;
  localparam logic [ADDR_W-1:0] A_UNLOCK = 8'hF1;
  localparam logic [ADDR_W-1:0] A_SLOWA = 8'hF2;
  localparam logic [NUM_REGS*ADDR_W-1:0] ADDR_TABLE = {
    A_SLOWA, A_UNLOCK, A_SLOWEN, A_PERF8, A_PERF67, A_PERF45, A_OFSLOOP, A_PEDB,
    A_PEDA, A_HFA, A_HFB, A_PDN, A_CLKPOS, A_IFC, A_WORD_LO, A_WORD_HI, A_OFSEN,
    A_CHB, A_FMT, A_CHA, A_PERF, A_SWING, A_CTRL};
  localparam int IDX_CTRL = 0;
  localparam int IDX_SWING = 1;
  localparam int IDX_PERF = 2;
  localparam int IDX_CHA = 3;
  localparam int IDX_FMT = 4;
  localparam int IDX_CHB = 5;
  localparam int IDX_WORD_HI = 7;
  localparam int IDX_WORD_LO = 8;
  localparam int IDX_UNLOCK = 21;
  localparam int BIT_READBACK = 0;
  localparam int BIT_SWRESET = 1;
  localparam logic [SAMPLE_W-1:0] TOGGLE_WORD = 14'h2AAA;
  typedef enum logic [2:0] {
    PAT_NORMAL, PAT_ZEROS, PAT_ONES, PAT_TOGGLE, PAT_RAMP, PAT_CUSTOM, PAT_UNUSED6, PAT_UNUSED7
  } pattern_e;
endpackage

//--- hw/cfg_wr_if.sv
// Write strobe and field bundle between the serial shifter and the register bank
`timescale 1ns/1ps
interface cfg_wr_if;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic frame;
  modport src (output wr_stb, output wr_addr, output wr_data, output frame);
  modport dst (input wr_stb, input wr_addr, input wr_data, input frame);
endinterface

//--- hw/serial_word_shifter.sv
// Sixteen-bit serial word assembler sampled on falling serial clock edges
`timescale 1ns/1ps
module serial_word_shifter
  import adc_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclk_fall,
  input wire logic sel_active,
  input wire logic serial_in_line_s,
  cfg_wr_if.src wr
);
  logic [WORD_BITS-2:0] shift_q;
  logic [4:0] cnt_q;
  logic word_done;
  assign word_done = sel_active && sclk_fall && (cnt_q == 5'(WORD_BITS - 1));
  assign wr.frame = sel_active;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_q <= '0;
      cnt_q <= CNT_RESET;
      wr.wr_stb <= 1'b0;
      wr.wr_addr <= '0;
      wr.wr_data <= '0;
    end
    else
    begin
      wr.wr_stb <= word_done;
      if (!sel_active)
        cnt_q <= CNT_RESET;
      else if (sclk_fall)
      begin
        shift_q <= {shift_q[WORD_BITS-3:0], serial_in_line_s};
        cnt_q <= word_done ? CNT_RESET : cnt_q + 5'h01;
      end
      if (word_done)
      begin
        wr.wr_addr <= shift_q[WORD_BITS-2:DATA_W-1];
        wr.wr_data <= {shift_q[DATA_W-2:0], serial_in_line_s};
      end
    end
  end
endmodule

//--- hw/pattern_source.sv
// Per-channel output source selection and data format
`timescale 1ns/1ps
module pattern_source
  import adc_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sample_stb,
  input wire logic [2:0] sel,
  input wire logic offset_binary,
  input wire logic [SAMPLE_W-1:0] conv_data,
  input wire logic [SAMPLE_W-1:0] custom_word,
  output logic [SAMPLE_W-1:0] data_out
);
  logic tog_q;
  logic [SAMPLE_W-1:0] ramp_q;
  logic [SAMPLE_W-1:0] conv_fmt;
  logic [SAMPLE_W-1:0] src_word;
  assign conv_fmt = offset_binary ? conv_data : {~conv_data[SAMPLE_W-1], conv_data[SAMPLE_W-2:0]};
  always_comb
  begin
    case (pattern_e'(sel))
      PAT_NORMAL: src_word = conv_fmt;
      PAT_ZEROS: src_word = '0;
      PAT_ONES: src_word = '1;
      PAT_TOGGLE: src_word = tog_q ? ~TOGGLE_WORD : TOGGLE_WORD;
      PAT_RAMP: src_word = ramp_q;
      PAT_CUSTOM: src_word = custom_word;
      default: src_word = conv_fmt;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tog_q <= 1'b0;
      ramp_q <= '0;
      data_out <= '0;
    end
    else if (sample_stb)
    begin
      tog_q <= ~tog_q;
      ramp_q <= ramp_q + 14'h0001;
      data_out <= src_word;
    end
  end
endmodule

//--- hw/adc_serial_config_registers.sv
// Configuration register bank with serial write and readback
`timescale 1ns/1ps
module adc_serial_config_registers
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic serial_clk,
  input wire logic serial_select_n,
  input wire logic serial_in_line,
  input wire logic sample_stb,
  input wire logic [adc_cfg_pkg::SAMPLE_W-1:0] conv_a,
  input wire logic [adc_cfg_pkg::SAMPLE_W-1:0] conv_b,
  output logic serial_readback_line,
  output logic serial_readback_oe_n,
  output logic [5:0] swing_code,
  output logic swing_unlocked,
  output logic best_performance_select,
  output logic [3:0] first_channel_gain,
  output logic [3:0] second_channel_gain,
  output logic [adc_cfg_pkg::SAMPLE_W-1:0] data_a,
  output logic [adc_cfg_pkg::SAMPLE_W-1:0] data_b
);
  import adc_cfg_pkg::*;

  // ******************************************************
  // Pin synchronisers and edge detect
  // ******************************************************
  logic [1:0] sclk_s_q, sel_s_q, sdi_s_q;
  logic sclk_prev_q;
  logic sclk_fall;
  logic sclk_rise;
  logic sel_active;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_s_q <= 2'h0;
      sel_s_q <= 2'h3;
      sdi_s_q <= 2'h0;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      sclk_s_q <= {sclk_s_q[0], serial_clk};
      sel_s_q <= {sel_s_q[0], serial_select_n};
      sdi_s_q <= {sdi_s_q[0], serial_in_line};
      sclk_prev_q <= sclk_s_q[1];
    end
  end
  assign sclk_fall = sclk_prev_q && !sclk_s_q[1];
  assign sclk_rise = !sclk_prev_q && sclk_s_q[1];
  assign sel_active = !sel_s_q[1];

  // ******************************************************
  // Word assembly
  // ******************************************************
  cfg_wr_if wr ();
  serial_word_shifter u_shift (
    .mclk(mclk),
    .rst_b(rst_b),
    .sclk_fall(sclk_fall),
    .sel_active(sel_active),
    .serial_in_line_s(sdi_s_q[1]),
    .wr(wr)
  );

  // ******************************************************
  // Register file
  // ******************************************************
  function automatic int unsigned addr_index(input logic [ADDR_W-1:0] a);
    int unsigned r;
    r = NUM_REGS;
    for (int i = 0; i < NUM_REGS; i++)
      if (ADDR_TABLE[i*ADDR_W +: ADDR_W] == a)
        r = i;
    return r;
  endfunction

  logic [DATA_W-1:0] regs_q [NUM_REGS];
  logic readback_on;
  logic soft_reset;
  int unsigned wr_idx;
  logic wr_hit;
  assign readback_on = regs_q[IDX_CTRL][BIT_READBACK];
  assign wr_idx = addr_index(wr.wr_addr);
  assign wr_hit = wr.wr_stb && (wr_idx < NUM_REGS) && !readback_on;
  assign soft_reset = wr_hit && (wr_idx == IDX_CTRL) && wr.wr_data[BIT_SWRESET];

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs_q[i] <= REG_RESET;
    end
    else if (soft_reset)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs_q[i] <= REG_RESET;
    end
    else if (wr_hit)
      regs_q[wr_idx] <= wr.wr_data;
  end

  // ******************************************************
  // Readback shifter
  // ******************************************************
  logic [4:0] rb_cnt_q;
  logic [DATA_W-1:0] rb_shift_q;
  int unsigned rb_idx;
  logic [ADDR_W-1:0] rb_addr_q;
  logic [ADDR_W-1:0] rb_addr_next;
  logic [DATA_W-1:0] rb_value;
  assign rb_addr_next = {rb_addr_q[ADDR_W-2:0], sdi_s_q[1]};
  assign rb_idx = addr_index(rb_addr_next);
  assign rb_value = (rb_idx < NUM_REGS) ? regs_q[rb_idx] : REG_RESET;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rb_cnt_q <= CNT_RESET;
      rb_shift_q <= '0;
      rb_addr_q <= '0;
      serial_readback_line <= 1'b0;
      serial_readback_oe_n <= 1'b1;
    end
    else
    begin
      serial_readback_oe_n <= !readback_on;
      if (!sel_active)
        rb_cnt_q <= CNT_RESET;
      else if (sclk_fall)
      begin
        rb_cnt_q <= (rb_cnt_q == 5'(WORD_BITS - 1)) ? CNT_RESET : rb_cnt_q + 5'h01;
        if (rb_cnt_q < 5'(ADDR_W))
          rb_addr_q <= rb_addr_next;
        if (rb_cnt_q == 5'(ADDR_W - 1))
          rb_shift_q <= rb_value;
        else
          rb_shift_q <= {rb_shift_q[DATA_W-2:0], 1'b0};
      end
      if (sclk_rise && readback_on && rb_cnt_q >= 5'(ADDR_W))
        serial_readback_line <= rb_shift_q[DATA_W-1];
      else if (!readback_on)
        serial_readback_line <= 1'b0;
    end
  end

  // ******************************************************
  // Field outputs
  // ******************************************************
  logic [SAMPLE_W-1:0] custom_word;
  logic offset_binary;
  assign custom_word = {regs_q[IDX_WORD_HI][5:0], regs_q[IDX_WORD_LO]};
  assign offset_binary = (regs_q[IDX_FMT][4:3] == 2'h3);
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      swing_code <= '0;
      swing_unlocked <= 1'b0;
      best_performance_select <= 1'b0;
      first_channel_gain <= '0;
      second_channel_gain <= '0;
    end
    else
    begin
      swing_code <= regs_q[IDX_SWING][7:2];
      swing_unlocked <= (regs_q[IDX_UNLOCK][1:0] == 2'h3);
      best_performance_select <= (regs_q[IDX_PERF][1:0] == 2'h3);
      first_channel_gain <= regs_q[IDX_CHA][7:4];
      second_channel_gain <= regs_q[IDX_CHB][7:4];
    end
  end

  pattern_source u_pat_a (
    .mclk(mclk),
    .rst_b(rst_b),
    .sample_stb(sample_stb),
    .sel(regs_q[IDX_CHA][2:0]),
    .offset_binary(offset_binary),
    .conv_data(conv_a),
    .custom_word(custom_word),
    .data_out(data_a)
  );
  pattern_source u_pat_b (
    .mclk(mclk),
    .rst_b(rst_b),
    .sample_stb(sample_stb),
    .sel(regs_q[IDX_CHB][2:0]),
    .offset_binary(offset_binary),
    .conv_data(conv_b),
    .custom_word(custom_word),
    .data_out(data_b)
  );

  // ******************************************************
  // Assertions
  // ******************************************************
  property p_swreset;
    @(posedge mclk) disable iff (!rst_b)
    soft_reset |=> (regs_q[IDX_CTRL] == REG_RESET) && (regs_q[IDX_CHA] == REG_RESET);
  endproperty
  a_swreset: assert property (p_swreset) else $error("soft reset left state");
  property p_float;
    @(posedge mclk) disable iff (!rst_b)
    !readback_on |=> serial_readback_oe_n;
  endproperty
  a_float: assert property (p_float) else $error("readback drove while off");
  property p_zero_after;
    @(posedge mclk) $rose(rst_b) |-> regs_q[IDX_SWING] == REG_RESET;
  endproperty
  a_zero_after: assert property (p_zero_after) else $error("nonzero after reset");
  property p_write;
    @(posedge mclk) disable iff (!rst_b)
    (wr_hit && !soft_reset) |=> regs_q[$past(wr_idx)] == $past(wr.wr_data);
  endproperty
  a_write: assert property (p_write) else $error("write lost");
  property p_gain;
    @(posedge mclk) disable iff (!rst_b)
    ##1 first_channel_gain == $past(regs_q[IDX_CHA][7:4]);
  endproperty
  a_gain: assert property (p_gain) else $error("gain mismatch");
  property p_perf;
    @(posedge mclk) disable iff (!rst_b)
    (regs_q[IDX_PERF][1:0] == 2'h3) [*2] |-> best_performance_select;
  endproperty
  a_perf: assert property (p_perf) else $error("perf select wrong");
  property p_block;
    @(posedge mclk) disable iff (!rst_b)
    (wr.wr_stb && readback_on) |=> $stable(regs_q[IDX_SWING]);
  endproperty
  a_block: assert property (p_block) else $error("write during readback");
  property p_strobe;
    @(posedge mclk) disable iff (!rst_b)
    wr.wr_stb |=> !wr.wr_stb;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe too long");
  property p_custom;
    @(posedge mclk) disable iff (!rst_b)
    (sample_stb && regs_q[IDX_CHA][2:0] == 3'h5) |=> data_a == $past(custom_word);
  endproperty
  a_custom: assert property (p_custom) else $error("custom word wrong");
  property p_drive;
    @(posedge mclk) disable iff (!rst_b)
    readback_on |=> !serial_readback_oe_n;
  endproperty
  a_drive: assert property (p_drive) else $error("readback line not driven");
  property p_quiet;
    @(posedge mclk) disable iff (!rst_b)
    !readback_on |=> !serial_readback_line;
  endproperty
  a_quiet: assert property (p_quiet) else $error("readback data while off");
  property p_swing;
    @(posedge mclk) disable iff (!rst_b)
    1'b1 |=> swing_code == $past(regs_q[IDX_SWING][7:2]);
  endproperty
  a_swing: assert property (p_swing) else $error("swing code mismatch");
  property p_gain_b;
    @(posedge mclk) disable iff (!rst_b)
    1'b1 |=> second_channel_gain == $past(regs_q[IDX_CHB][7:4]);
  endproperty
  a_gain_b: assert property (p_gain_b) else $error("second gain mismatch");
  property p_ones;
    @(posedge mclk) disable iff (!rst_b)
    (sample_stb && regs_q[IDX_CHA][2:0] == 3'h2) |=> data_a == '1;
  endproperty
  a_ones: assert property (p_ones) else $error("all ones pattern wrong");
  property p_zeros_b;
    @(posedge mclk) disable iff (!rst_b)
    (sample_stb && regs_q[IDX_CHB][2:0] == 3'h1) |=> data_b == '0;
  endproperty
  a_zeros_b: assert property (p_zeros_b) else $error("second zeros pattern wrong");
  property p_raw;
    @(posedge mclk) disable iff (!rst_b)
    (sample_stb && regs_q[IDX_CHB][2:0] == 3'h0 && offset_binary) |=> data_b == $past(conv_b);
  endproperty
  a_raw: assert property (p_raw) else $error("offset binary data wrong");
  property p_twos;
    @(posedge mclk) disable iff (!rst_b)
    (sample_stb && regs_q[IDX_CHA][2:0] == 3'h0 && !offset_binary) |=>
      data_a == {~$past(conv_a[SAMPLE_W-1]), $past(conv_a[SAMPLE_W-2:0])};
  endproperty
  a_twos: assert property (p_twos) else $error("twos complement data wrong");
  property p_toggle;
    @(posedge mclk) disable iff (!rst_b)
    (sample_stb && regs_q[IDX_CHA][2:0] == 3'h3) |=>
      data_a == ($past(u_pat_a.tog_q) ? ~TOGGLE_WORD : TOGGLE_WORD);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle word wrong");
  property p_alternate;
    @(posedge mclk) disable iff (!rst_b)
    sample_stb |=> u_pat_a.tog_q != $past(u_pat_a.tog_q);
  endproperty
  a_alternate: assert property (p_alternate) else $error("toggle phase stuck");
  property p_discard;
    @(posedge mclk) disable iff (!rst_b)
    !sel_active |=> !wr.wr_stb;
  endproperty
  a_discard: assert property (p_discard) else $error("write outside frame");
  property p_frame;
    @(posedge mclk) disable iff (!rst_b)
    wr.wr_stb |-> $past(wr.frame);
  endproperty
  a_frame: assert property (p_frame) else $error("strobe without frame");
  c_write: cover property (@(posedge mclk) disable iff (!rst_b) wr_hit);
  c_reset: cover property (@(posedge mclk) disable iff (!rst_b) soft_reset);
  c_readback: cover property (@(posedge mclk) disable iff (!rst_b)
    readback_on && !serial_readback_oe_n && sclk_rise);
  c_custom: cover property (@(posedge mclk) disable iff (!rst_b)
    sample_stb && regs_q[IDX_CHA][2:0] == 3'h5);
  c_toggle: cover property (@(posedge mclk) disable iff (!rst_b)
    sample_stb && regs_q[IDX_CHB][2:0] == 3'h3);
endmodule

//--- sim/serial_ctrl_model.sv
// Behavioural four-wire serial controller that writes frames and captures readback
`timescale 1ns/1ps
module serial_ctrl_model
(
  output logic serial_clk,
  output logic serial_select_n,
  output logic serial_in_line,
  input wire logic rb_pin
);
  logic [7:0] rx;
  initial
  begin
    serial_clk = 1'b0;
    serial_select_n = 1'b1;
    serial_in_line = 1'b1;
    rx = 8'h00;
  end
  // ***************************************
  // Frame of n bits from w, MSB first
  // ***************************************
  task automatic send(input logic [31:0] w, input int n);
    serial_select_n = 1'b0;
    #40;
    for (int i = 0; i < n; i++)
    begin
      serial_in_line = w[31-i];
      #2 serial_clk = 1'b1;
      #32 serial_clk = 1'b0;
      #30;
      if (i >= 8 && i < 16)
        rx = {rx[6:0], rb_pin};
    end
    serial_select_n = 1'b1;
    serial_in_line = ~serial_in_line;
    #40;
  endtask
endmodule

//--- sim/adc_serial_config_registers_tb.sv
// Self-checking bench for the converter configuration register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", n, (e), (g)); end end
module adc_serial_config_registers_tb;
  import adc_cfg_pkg::*;
  logic mclk, rst_b, sample_stb;
  logic [13:0] conv_a, conv_b;
  logic [7:0] d;
  wire serial_clk, serial_select_n, serial_in_line, rb_line, rb_oe_n, rb_pin;
  wire [5:0] swing_code;
  wire swing_unlocked, best_performance_select;
  wire [3:0] first_channel_gain, second_channel_gain;
  wire [13:0] data_a, data_b;
  int err_count, checks_done, seed, nsamp;
  logic [7:0] m [0:255];
  logic [7:0] msk [0:22] = '{8'h03, 8'hFC, 8'h03, 8'hF7, 8'h18, 8'hF7, 8'h20, 8'h3F,
    8'hFF, 8'hF3, 8'hF8, 8'hE4, 8'h01, 8'h01, 8'hFC, 8'hFC, 8'hBC, 8'h18, 8'h0C,
    8'h21, 8'h10, 8'h03, 8'h08};
  logic [7:0] swc [0:5] = '{8'h00, 8'h1B, 8'h32, 8'h14, 8'h3E, 8'h0F};
  assign rb_pin = rb_oe_n ? 1'bz : rb_line;
  serial_ctrl_model ctl (.serial_clk(serial_clk), .serial_select_n(serial_select_n),
    .serial_in_line(serial_in_line), .rb_pin(rb_pin));
  adc_serial_config_registers dut (.mclk(mclk), .rst_b(rst_b), .serial_clk(serial_clk),
    .serial_select_n(serial_select_n), .serial_in_line(serial_in_line),
    .sample_stb(sample_stb), .conv_a(conv_a), .conv_b(conv_b),
    .serial_readback_line(rb_line), .serial_readback_oe_n(rb_oe_n),
    .swing_code(swing_code), .swing_unlocked(swing_unlocked),
    .best_performance_select(best_performance_select),
    .first_channel_gain(first_channel_gain), .second_channel_gain(second_channel_gain),
    .data_a(data_a), .data_b(data_b));
  // ***************************************
  // Reference model and bus tasks
  // ***************************************
  function automatic bit is_map(input logic [7:0] a);
    for (int i = 0; i < NUM_REGS; i++)
      if (ADDR_TABLE[i*8 +: 8] == a)
        return 1'b1;
    return 1'b0;
  endfunction
  task automatic mdl(input logic [7:0] a, input logic [7:0] v);
    if (m[A_CTRL][BIT_READBACK] !== 1'b1 && is_map(a))
    begin
      if (a == A_CTRL && v[BIT_SWRESET])
        foreach (m[k])
          m[k] = 8'h00;
      else
        m[a] = (a == A_CTRL) ? (v & 8'h01) : v;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    ctl.send({a, v, 16'h0000}, 16);
    mdl(a, v);
    repeat (8) @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    ctl.send({a, 24'h000000}, 16);
    repeat (8) @(negedge mclk);
    `CHK("readback", m[a], ctl.rx)
  endtask
  task automatic chk_out;
    `CHK("swing", m[A_SWING][7:2], swing_code)
    `CHK("unlock", m[A_UNLOCK][1:0] == 2'b11, swing_unlocked)
    `CHK("perf", m[A_PERF][1:0] == 2'b11, best_performance_select)
    `CHK("gain_a", m[A_CHA][7:4], first_channel_gain)
    `CHK("gain_b", m[A_CHB][7:4], second_channel_gain)
  endtask
  function automatic logic [13:0] exp14(input logic [2:0] s, input logic [13:0] cv);
    case (s)
      3'd1: return 14'h0000;
      3'd2: return 14'h3FFF;
      3'd3: return nsamp[0] ? ~TOGGLE_WORD : TOGGLE_WORD;
      3'd4: return 14'(nsamp);
      3'd5: return {m[A_WORD_HI][5:0], m[A_WORD_LO]};
      default: return (m[A_FMT][4:3] == 2'b11) ? cv : {~cv[13], cv[12:0]};
    endcase
  endfunction
  task automatic samp(input logic [2:0] sa, input logic [2:0] sb);
    logic [13:0] ca;
    logic [13:0] cb;
    ca = 14'($random(seed));
    cb = 14'($random(seed));
    conv_a = ca;
    conv_b = cb;
    sample_stb = 1'b1;
    @(negedge mclk);
    sample_stb = 1'b0;
    repeat (2) @(negedge mclk);
    `CHK("data_a", exp14(sa, ca), data_a)
    `CHK("data_b", exp14(sb, cb), data_b)
    nsamp++;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ***************************************
  // Clock, watchdog and scenarios
  // ***************************************
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    repeat (100000) @(posedge mclk);
    err_count++;
    complete_run();
  end
  initial
  begin
    seed = 32'hdb74;
    rst_b = 1'b0;
    sample_stb = 1'b0;
    conv_a = 14'h0000;
    conv_b = 14'h0000;
    nsamp = 0;
    foreach (m[k])
      m[k] = 8'h00;
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    `CHK("oe_n", 1'b1, rb_oe_n)
    chk_out();
    wr(A_UNLOCK, 8'h03);
    for (int i = 0; i < 6; i++)
    begin
      wr(A_SWING, swc[i]);
      chk_out();
    end
    wr(A_PERF, 8'h03);
    chk_out();
    for (int g = 0; g < 13; g++)
    begin
      wr(A_CHA, {4'(g), 4'h0});
      wr(A_CHB, {4'(12 - g), 4'h0});
      chk_out();
    end
    ctl.send({A_CHA, 8'hC5, A_CHB, 8'h34}, 32);
    mdl(A_CHA, 8'hC5);
    mdl(A_CHB, 8'h34);
    ctl.send({A_CHA, 8'h10, A_CHB, 8'h00}, 21);
    mdl(A_CHA, 8'h10);
    repeat (8) @(negedge mclk);
    chk_out();
    wr(A_WORD_HI, 8'($random(seed)) & 8'h3F);
    wr(A_WORD_LO, 8'($random(seed)));
    for (int c = 0; c < 8; c++)
    begin
      wr(A_FMT, {3'b000, 2'(c), 3'b000});
      wr(A_CHA, {4'(c), 1'b0, 3'(c)});
      wr(A_CHB, {4'(c + 4), 1'b0, 3'(7 - c)});
      chk_out();
      for (int k = 0; k < 3; k++)
        samp(3'(c), 3'(7 - c));
    end
    wr(A_CTRL, 8'h02);
    chk_out();
    wr(A_UNLOCK, 8'h03);
    for (int i = 1; i < NUM_REGS; i++)
    begin
      d = 8'($random(seed)) & msk[i];
      if (i == IDX_PERF)
        d = {6'h00, {2{d[0]}}};
      if (i == IDX_CHA || i == IDX_CHB)
        d[7:4] = d[7:4] % 4'd13;
      if (i == IDX_UNLOCK)
        d = 8'h03;
      wr(ADDR_TABLE[i*8 +: 8], d);
    end
    wr(8'h02, 8'h55);
    chk_out();
    wr(A_CTRL, 8'h01);
    wr(A_CHA, 8'h77);
    chk_out();
    for (int i = 0; i < NUM_REGS; i++)
      rd(ADDR_TABLE[i*8 +: 8]);
    rd(8'h02);
    rd(8'hAA);
    rst_b = 1'b0;
    @(negedge mclk);
    rst_b = 1'b1;
    nsamp = 0;
    foreach (m[k])
      m[k] = 8'h00;
    repeat (3) @(negedge mclk);
    `CHK("oe_n", 1'b1, rb_oe_n)
    wr(A_CTRL, 8'h01);
    for (int i = 0; i < NUM_REGS; i++)
      rd(ADDR_TABLE[i*8 +: 8]);
    complete_run();
  end
endmodule
